// ### include/tdlb_regs.vh
// Register map, field positions, reset values and timing counts for the T1 data link block
// What this block does
// (RL1) Code generator works only in T1 mode
// (RL2) Outgoing code is low six register bits
// (RL3) Send-code bit starts code insertion at once
// (RL4) Generator makes the abort sequence itself
// (RL5) Code repeats while send-code bit stays set
// (RL6) Host clears pass-through so codes replace F-bits
// (RL7) Code detector only in ESF, data-link bits
// (RL8) Detect flag after filtered persistence; code readable
// (RL9) Detect stays clear until new or re-detected code
// (RL10) Clear flag after code absent for disintegration
// (RL11) Code flags drive masked active-low interrupt
// (RL12) Source select sends link byte into stream
// (RL13) Link byte serialised least significant bit first
// (RL14) Empty flag after eight bits, masked interrupt
// (RL15) Host rewrites link byte within 2 ms
// (RL16) Unrewritten link byte is sent again
// (RL17) No zero stuffing on sent link byte
// (RL18) Host loads 1Ch, clears select for D4
// (RL19) D4 sends only lower six bits
// (RL20) Receive byte LSB first, full flag, interrupt
// (RL21) Host reads received byte within 2 ms
// (RL22) No zero destuffing on received byte
// (RL23) D4 receive updates per multiframe, Fs only
// (RL24) Framer n registers at base plus (n-1)*200h
// (RL25) Clearing send-code returns normal link source
`ifndef TDLB_REGS_VH
`define TDLB_REGS_VH

// Register offsets for the first framer
`define TDLB_OFF_RX_CODE_CONTROL 12'h015
`define TDLB_OFF_RX_LINK_BYTE 12'h062
`define TDLB_OFF_RX_CODE_WORD 12'h063
`define TDLB_OFF_RX_LATCHED_STATUS_SEVEN 12'h096
`define TDLB_OFF_RX_INTERRUPT_MASK_SEVEN 12'h0A6
`define TDLB_OFF_TX_LINK_CONTROL_TWO 12'h113
`define TDLB_OFF_TX_LINK_BYTE 12'h162
`define TDLB_OFF_TX_CODE_WORD 12'h163
`define TDLB_OFF_TX_CONTROL_ONE 12'h181
`define TDLB_OFF_TX_CONTROL_TWO 12'h182
`define TDLB_OFF_TX_LATCHED_STATUS_TWO 12'h191
`define TDLB_OFF_TX_INTERRUPT_MASK_TWO 12'h1A1
`define TDLB_FRAMER_STRIDE 12'h200

// Field positions
`define TDLB_BIT_SEND_CODE 6
`define TDLB_BIT_PASSTHROUGH 6
`define TDLB_BIT_SOURCE_SEL 7
`define TDLB_BIT_CODE_DETECT 0
`define TDLB_BIT_CODE_CLEAR 1
`define TDLB_BIT_RX_FULL 2
`define TDLB_BIT_TX_EMPTY 4
`define TDLB_BIT_FILTER_LO 0
`define TDLB_BIT_DISINT_LO 4

// Reset values
`define TDLB_RST_REG 8'h00
`define TDLB_RST_PATTERN 16'hFFFF

// Timing counts: filter counts in codewords, the rest in data-link bit slots
`define TDLB_FILT_CNT0 3'h1
`define TDLB_FILT_CNT1 3'h3
`define TDLB_FILT_CNT2 3'h5
`define TDLB_FILT_CNT3 3'h7
`define TDLB_DIS_CNT0 8'h20
`define TDLB_DIS_CNT1 8'h40
`define TDLB_DIS_CNT2 8'h80
`define TDLB_DIS_CNT3 8'hFF
`define TDLB_ABORT_BITS 4'h8
`define TDLB_ESF_LAST 3'h7
`define TDLB_D4_LAST 3'h5

`endif

// ### rtl/tdlb_link.v
// T1 data link block: code generator and detector, legacy link byte transmit and receive
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tdlb_regs.vh"

module tdlb_link #(
  parameter [3:0] FRAMER_NUM = 4'h1 // Framer instance, 1 to 8
) (
  input wire clk_sys,
  input wire rst,
  input wire [11:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire line_t1_mode,
  input wire line_esf_mode,
  input wire tx_link_slot,
  input wire tx_serial_fbit,
  output reg tx_link_bit_q,
  output reg tx_link_valid_q,
  input wire rx_link_slot,
  input wire rx_link_bit,
  input wire rx_mf_start,
  output reg interrupt_out_n_q
);

  // Software registers
  reg [7:0] rx_code_control_q; // Filter and disintegration selects
  reg [7:0] rx_interrupt_mask_seven_q; // Mask for receive flags
  reg [7:0] tx_link_control_two_q; // Holds the send-code bit
  reg [7:0] tx_link_byte_q; // Byte to be shifted out
  reg [7:0] tx_code_word_q; // Outgoing code in low bits
  reg [7:0] tx_control_one_q; // Holds the pass-through bit
  reg [7:0] tx_control_two_q; // Holds the source select
  reg [7:0] tx_interrupt_mask_two_q; // Mask for empty flag
  reg [7:0] rx_link_byte_q; // Last received byte
  reg [5:0] rx_code_word_q; // Last reported code
  reg [2:0] rx_status_q; // Detect, clear, full
  reg tx_empty_q; // Transmit byte empty flag

  // Transmit code engine
  localparam [1:0] CODE_IDLE = 2'b00;
  localparam [1:0] CODE_SEND = 2'b01;
  localparam [1:0] CODE_ABORT = 2'b10;
  reg [1:0] code_state_q;
  reg [15:0] code_pat_q; // Pattern being sent
  reg [3:0] code_idx_q; // Bit index in pattern or abort
  reg [7:0] tx_sh_q; // Byte shift register
  reg [2:0] tx_cnt_q; // Bit index in byte

  // Receive side
  reg [7:0] rx_sh_q; // Receive shift register
  reg [2:0] rx_cnt_q; // Receive bit index
  reg [15:0] rx_win_q; // Sliding code window
  reg [5:0] cand_code_q; // Code being filtered
  reg [2:0] cand_cnt_q; // Matching codewords seen
  reg [7:0] idle_cnt_q; // Slots since last match
  reg code_active_q; // A code is currently reported

  // Address of a register for this framer instance
  function hit;
    input [11:0] a;
    input [11:0] off;
    begin
      hit = (a == off + (({8'h00, FRAMER_NUM} - 12'h001) * `TDLB_FRAMER_STRIDE)); // RL24
    end
  endfunction

  // Codeword as sent, oldest bit at position 0: zero, six code bits, zero, eight ones
  function [15:0] code_pattern;
    input [5:0] c;
    begin
      code_pattern = {8'hFF, 1'b0, c, 1'b0};
    end
  endfunction

  // Codeword persistence needed for a detect
  function [2:0] filt_need;
    input [1:0] sel;
    begin
      if (sel == 2'b00) begin
        filt_need = `TDLB_FILT_CNT0;
      end else if (sel == 2'b01) begin
        filt_need = `TDLB_FILT_CNT1;
      end else if (sel == 2'b10) begin
        filt_need = `TDLB_FILT_CNT2;
      end else begin
        filt_need = `TDLB_FILT_CNT3;
      end
    end
  endfunction

  // Absence time needed before a code counts as cleared
  function [7:0] dis_need;
    input [1:0] sel;
    begin
      if (sel == 2'b00) begin
        dis_need = `TDLB_DIS_CNT0;
      end else if (sel == 2'b01) begin
        dis_need = `TDLB_DIS_CNT1;
      end else if (sel == 2'b10) begin
        dis_need = `TDLB_DIS_CNT2;
      end else begin
        dis_need = `TDLB_DIS_CNT3;
      end
    end
  endfunction

  // Decoded control
  wire code_mode = line_t1_mode & line_esf_mode; // Code logic only on T1 ESF
  wire send_code = tx_link_control_two_q[`TDLB_BIT_SEND_CODE];
  wire passthrough = tx_control_one_q[`TDLB_BIT_PASSTHROUGH];
  wire src_sel = tx_control_two_q[`TDLB_BIT_SOURCE_SEL];
  // ESF takes the byte when select is set, D4 sources Fs from it when select is clear
  wire byte_src = line_t1_mode & (line_esf_mode ? src_sel : ~src_sel); // RL12
  wire [2:0] tx_last = line_esf_mode ? `TDLB_ESF_LAST : `TDLB_D4_LAST; // RL19
  wire [2:0] rx_last = line_esf_mode ? `TDLB_ESF_LAST : `TDLB_D4_LAST;
  wire code_busy = (code_state_q != CODE_IDLE);

  // Receive window after this slot's bit and its match test
  wire [15:0] win_next = {rx_link_bit, rx_win_q[15:1]};
  wire [5:0] win_code = win_next[6:1];
  wire win_match = (win_next[15:8] == 8'hFF) & ~win_next[7] & ~win_next[0] & (win_code != 6'h3F);
  wire [2:0] need = filt_need(rx_code_control_q[`TDLB_BIT_FILTER_LO +: 2]);
  wire [7:0] dis = dis_need(rx_code_control_q[`TDLB_BIT_DISINT_LO +: 2]);

  // Write strobes per register
  wire wr_rbc = reg_wr & hit(reg_addr, `TDLB_OFF_RX_CODE_CONTROL);
  wire wr_rls = reg_wr & hit(reg_addr, `TDLB_OFF_RX_LATCHED_STATUS_SEVEN);
  wire wr_rim = reg_wr & hit(reg_addr, `TDLB_OFF_RX_INTERRUPT_MASK_SEVEN);
  wire wr_thc = reg_wr & hit(reg_addr, `TDLB_OFF_TX_LINK_CONTROL_TWO);
  wire wr_tfb = reg_wr & hit(reg_addr, `TDLB_OFF_TX_LINK_BYTE);
  wire wr_tcw = reg_wr & hit(reg_addr, `TDLB_OFF_TX_CODE_WORD);
  wire wr_tc1 = reg_wr & hit(reg_addr, `TDLB_OFF_TX_CONTROL_ONE);
  wire wr_tc2 = reg_wr & hit(reg_addr, `TDLB_OFF_TX_CONTROL_TWO);
  wire wr_tls = reg_wr & hit(reg_addr, `TDLB_OFF_TX_LATCHED_STATUS_TWO);
  wire wr_tim = reg_wr & hit(reg_addr, `TDLB_OFF_TX_INTERRUPT_MASK_TWO);

  // Plain read/write registers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_code_control_q <= `TDLB_RST_REG;
      rx_interrupt_mask_seven_q <= `TDLB_RST_REG;
      tx_link_control_two_q <= `TDLB_RST_REG;
      tx_link_byte_q <= `TDLB_RST_REG;
      tx_code_word_q <= `TDLB_RST_REG;
      tx_control_one_q <= `TDLB_RST_REG;
      tx_control_two_q <= `TDLB_RST_REG;
      tx_interrupt_mask_two_q <= `TDLB_RST_REG;
    end else begin
      if (wr_rbc) begin
        rx_code_control_q <= reg_wdata;
      end
      if (wr_rim) begin
        rx_interrupt_mask_seven_q <= reg_wdata;
      end
      if (wr_thc) begin
        tx_link_control_two_q <= reg_wdata;
      end
      if (wr_tfb) begin
        tx_link_byte_q <= reg_wdata;
      end
      if (wr_tcw) begin
        tx_code_word_q <= reg_wdata;
      end
      if (wr_tc1) begin
        tx_control_one_q <= reg_wdata;
      end
      if (wr_tc2) begin
        tx_control_two_q <= reg_wdata;
      end
      if (wr_tim) begin
        tx_interrupt_mask_two_q <= reg_wdata;
      end
    end
  end

  // Read mux, data appear one cycle after the strobe; unmapped reads give zero
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= `TDLB_RST_REG;
    end else if (!reg_rd) begin
      reg_rdata_q <= `TDLB_RST_REG;
    end else if (hit(reg_addr, `TDLB_OFF_RX_CODE_CONTROL)) begin
      reg_rdata_q <= rx_code_control_q;
    end else if (hit(reg_addr, `TDLB_OFF_RX_LINK_BYTE)) begin
      reg_rdata_q <= rx_link_byte_q;
    end else if (hit(reg_addr, `TDLB_OFF_RX_CODE_WORD)) begin
      reg_rdata_q <= {2'b00, rx_code_word_q}; // RL8
    end else if (hit(reg_addr, `TDLB_OFF_RX_LATCHED_STATUS_SEVEN)) begin
      reg_rdata_q <= {5'b00000, rx_status_q};
    end else if (hit(reg_addr, `TDLB_OFF_RX_INTERRUPT_MASK_SEVEN)) begin
      reg_rdata_q <= rx_interrupt_mask_seven_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_LINK_CONTROL_TWO)) begin
      reg_rdata_q <= tx_link_control_two_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_LINK_BYTE)) begin
      reg_rdata_q <= tx_link_byte_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_CODE_WORD)) begin
      reg_rdata_q <= tx_code_word_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_CONTROL_ONE)) begin
      reg_rdata_q <= tx_control_one_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_CONTROL_TWO)) begin
      reg_rdata_q <= tx_control_two_q;
    end else if (hit(reg_addr, `TDLB_OFF_TX_LATCHED_STATUS_TWO)) begin
      reg_rdata_q <= {3'b000, tx_empty_q, 4'h0};
    end else if (hit(reg_addr, `TDLB_OFF_TX_INTERRUPT_MASK_TWO)) begin
      reg_rdata_q <= tx_interrupt_mask_two_q;
    end else begin
      reg_rdata_q <= `TDLB_RST_REG;
    end
  end

  // Code generator; pattern reloads only at a codeword boundary, so a code change never tears one
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      code_state_q <= CODE_IDLE;
      code_pat_q <= `TDLB_RST_PATTERN;
      code_idx_q <= 4'h0;
    end else begin
      case (code_state_q)
        CODE_IDLE: begin
          // Start at once, next slot carries the first code bit
          if (send_code && code_mode) begin // RL1 RL3
            code_state_q <= CODE_SEND;
            code_pat_q <= code_pattern(tx_code_word_q[5:0]); // RL2
            code_idx_q <= 4'h0;
          end
        end
        CODE_SEND: begin
          if (!send_code || !code_mode) begin
            // Generator closes the message with ones on its own
            code_state_q <= CODE_ABORT; // RL4
            code_idx_q <= 4'h0;
          end else if (tx_link_slot) begin
            code_idx_q <= code_idx_q + 4'h1;
            if (code_idx_q == 4'hF) begin
              code_pat_q <= code_pattern(tx_code_word_q[5:0]); // RL5
            end
          end
        end
        CODE_ABORT: begin
          if (tx_link_slot) begin
            code_idx_q <= code_idx_q + 4'h1;
            if (code_idx_q == `TDLB_ABORT_BITS - 4'h1) begin
              code_state_q <= CODE_IDLE; // RL25
            end
          end
        end
        default: begin
          code_state_q <= CODE_IDLE;
        end
      endcase
    end
  end

  // Link byte serialiser; byte sampled at its first bit, so an unwritten one repeats; no zero insertion
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_sh_q <= `TDLB_RST_REG;
      tx_cnt_q <= 3'h0;
    end else if (tx_link_slot && byte_src && !code_busy) begin
      if (tx_cnt_q == 3'h0) begin
        tx_sh_q <= {1'b0, tx_link_byte_q[7:1]}; // RL16 RL17
      end else begin
        tx_sh_q <= {1'b0, tx_sh_q[7:1]}; // RL13
      end
      if (tx_cnt_q == tx_last) begin
        tx_cnt_q <= 3'h0; // RL19
      end else begin
        tx_cnt_q <= tx_cnt_q + 3'h1;
      end
    end
  end

  // Outgoing link bit; pass-through keeps the sampled F-bit untouched
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_link_bit_q <= 1'b0;
      tx_link_valid_q <= 1'b0;
    end else begin
      tx_link_valid_q <= tx_link_slot;
      if (tx_link_slot) begin
        if (passthrough) begin
          tx_link_bit_q <= tx_serial_fbit; // RL6
        end else if (code_state_q == CODE_SEND && send_code && code_mode) begin
          tx_link_bit_q <= code_pat_q[code_idx_q];
        end else if (code_busy && line_t1_mode) begin
          tx_link_bit_q <= 1'b1; // RL4
        end else if (byte_src) begin
          tx_link_bit_q <= (tx_cnt_q == 3'h0) ? tx_link_byte_q[0] : tx_sh_q[0]; // RL12 RL13
        end else begin
          tx_link_bit_q <= tx_serial_fbit; // RL25
        end
      end
    end
  end

  // Transmit empty flag, set wins over a same-cycle clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_empty_q <= 1'b0;
    end else if (tx_link_slot && byte_src && !code_busy && tx_cnt_q == tx_last) begin
      tx_empty_q <= 1'b1; // RL14
    end else if (wr_tls && reg_wdata[`TDLB_BIT_TX_EMPTY]) begin
      tx_empty_q <= 1'b0;
    end
  end

  // Receive byte deserialiser, LSB first, no zero removal; D4 aligns to the multiframe
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_sh_q <= `TDLB_RST_REG;
      rx_cnt_q <= 3'h0;
      rx_link_byte_q <= `TDLB_RST_REG;
    end else if (rx_link_slot) begin
      rx_sh_q <= {rx_link_bit, rx_sh_q[7:1]}; // RL20 RL22
      if (!line_esf_mode && rx_mf_start) begin
        rx_cnt_q <= 3'h1; // RL23
      end else if (rx_cnt_q == rx_last) begin
        rx_cnt_q <= 3'h0;
        if (line_esf_mode) begin
          rx_link_byte_q <= {rx_link_bit, rx_sh_q[7:1]}; // RL20
        end else begin
          rx_link_byte_q <= {2'b00, rx_link_bit, rx_sh_q[7:3]}; // RL23
        end
      end else begin
        rx_cnt_q <= rx_cnt_q + 3'h1;
      end
    end
  end

  wire rx_full_set = rx_link_slot && !(!line_esf_mode && rx_mf_start) && rx_cnt_q == rx_last;
  // Code detector: filter on repeated identical codewords, clear on absence
  wire cand_same = (win_code == cand_code_q);
  wire [2:0] cand_next = cand_same ? ((cand_cnt_q == 3'h7) ? cand_cnt_q : cand_cnt_q + 3'h1) : 3'h1;
  wire det_set = rx_link_slot && code_mode && win_match && (cand_next >= need) &&
                 (!code_active_q || win_code != rx_code_word_q);
  wire clr_set = rx_link_slot && code_mode && !win_match && code_active_q && idle_cnt_q == dis - 8'h01;
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_win_q <= 16'h0000;
      cand_code_q <= 6'h00;
      cand_cnt_q <= 3'h0;
      idle_cnt_q <= 8'h00;
      code_active_q <= 1'b0;
      rx_code_word_q <= 6'h00;
    end else if (!code_mode) begin
      // Outside T1 ESF the detector rests
      cand_cnt_q <= 3'h0; // RL7
      idle_cnt_q <= 8'h00;
      code_active_q <= 1'b0;
    end else if (rx_link_slot) begin
      rx_win_q <= win_next;
      if (win_match) begin
        cand_code_q <= win_code;
        cand_cnt_q <= cand_next;
        idle_cnt_q <= 8'h00;
        if (det_set) begin
          code_active_q <= 1'b1;
          rx_code_word_q <= win_code; // RL8
        end
      end else if (idle_cnt_q != 8'hFF) begin
        idle_cnt_q <= idle_cnt_q + 8'h01;
        if (clr_set) begin
          code_active_q <= 1'b0; // RL9 RL10
          cand_cnt_q <= 3'h0;
        end
      end
    end
  end

  // Receive latched flags, write one to clear, set wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_status_q <= 3'b000;
    end else begin
      rx_status_q[`TDLB_BIT_CODE_DETECT] <= det_set |
        (rx_status_q[`TDLB_BIT_CODE_DETECT] & ~(wr_rls & reg_wdata[`TDLB_BIT_CODE_DETECT])); // RL8 RL9
      rx_status_q[`TDLB_BIT_CODE_CLEAR] <= clr_set |
        (rx_status_q[`TDLB_BIT_CODE_CLEAR] & ~(wr_rls & reg_wdata[`TDLB_BIT_CODE_CLEAR])); // RL10
      rx_status_q[`TDLB_BIT_RX_FULL] <= rx_full_set |
        (rx_status_q[`TDLB_BIT_RX_FULL] & ~(wr_rls & reg_wdata[`TDLB_BIT_RX_FULL])); // RL20
    end
  end

  // Interrupt pin, low while any unmasked flag stands
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      interrupt_out_n_q <= 1'b1;
    end else begin
      interrupt_out_n_q <= ~(|(rx_status_q & rx_interrupt_mask_seven_q[2:0]) | // RL11 RL20
                             (tx_empty_q & tx_interrupt_mask_two_q[`TDLB_BIT_TX_EMPTY])); // RL14
    end
  end
endmodule
`default_nettype wire

// ### testbench/tdlb_far_end.sv
// Far-end line model: slot timing, received link bits, captured sent bits
`timescale 1ns/10ps
`default_nettype none
module tdlb_far_end #(
  parameter int GAP = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] rx_pattern,
  input wire logic [4:0] rx_len,
  input wire logic d4_mode,
  input wire logic tx_link_bit_q,
  input wire logic tx_link_valid_q,
  output logic tx_link_slot,
  output logic rx_link_slot,
  output logic rx_link_bit,
  output logic rx_mf_start,
  output logic [31:0] tx_hist
);
  logic [3:0] ph_q; // Place in the slot period
  logic [4:0] idx_q; // Next pattern bit
  // Slots every GAP cycles; the data line toggles between slots so a stale bit never looks valid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph_q <= 4'h0;
      idx_q <= 5'h00;
      tx_link_slot <= 1'b0;
      rx_link_slot <= 1'b0;
      rx_link_bit <= 1'b0;
      rx_mf_start <= 1'b0;
      tx_hist <= 32'h0000_0000;
    end else begin
      ph_q <= (ph_q == 4'(GAP - 1)) ? 4'h0 : ph_q + 4'h1;
      tx_link_slot <= ph_q == 4'h0;
      rx_link_slot <= ph_q == 4'(GAP / 2);
      rx_mf_start <= ph_q == 4'(GAP / 2) && d4_mode && idx_q == 5'h00;
      if (ph_q == 4'(GAP / 2)) begin
        rx_link_bit <= rx_pattern[idx_q[3:0]];
        idx_q <= (idx_q >= rx_len - 5'h01) ? 5'h00 : idx_q + 5'h01;
      end else begin
        rx_link_bit <= ~rx_link_bit;
      end
      // Newest bit enters at the top, so a byte sent LSB first reads straight
      if (tx_link_valid_q) tx_hist <= {tx_link_bit_q, tx_hist[31:1]};
    end
  end
endmodule
`default_nettype wire

// ### testbench/tdlb_link_monitor.sv
// Checker for the T1 data link block, bound to its ports
`timescale 1ns/10ps
`default_nettype none
module tdlb_link_monitor #(
  parameter logic [3:0] FRAMER_NUM = 4'h1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic line_t1_mode,
  input wire logic line_esf_mode,
  input wire logic tx_link_slot,
  input wire logic tx_serial_fbit,
  input wire logic tx_link_bit_q,
  input wire logic tx_link_valid_q,
  input wire logic rx_link_slot,
  input wire logic rx_link_bit,
  input wire logic rx_mf_start,
  input wire logic interrupt_out_n_q
);
  localparam logic [11:0] BASE = (FRAMER_NUM - 4'h1) * 12'h200; // Window of this framer
  logic pt_q; // Pass-through shadow
  logic sc_q; // Send-code shadow
  logic hold_q; // Send-code just cleared
  logic [3:0] ab_q; // Abort slots left to check
  logic [3:0] msk_q; // Interrupt mask shadow
  logic [7:0] code_q; // Outgoing code shadow
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  function automatic logic wr_at(input logic [11:0] off);
    return reg_wr && reg_addr == BASE + off;
  endfunction
  // Shadows follow host writes; only seven abort slots are checked, since
  // the slot right after the clear may still carry a code bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pt_q <= 1'b0;
      sc_q <= 1'b0;
      hold_q <= 1'b0;
      ab_q <= 4'h0;
      msk_q <= 4'h0;
      code_q <= 8'h00;
    end else begin
      hold_q <= wr_at(12'h113) && !reg_wdata[6] && sc_q;
      if (wr_at(12'h113)) sc_q <= reg_wdata[6];
      if (wr_at(12'h181)) pt_q <= reg_wdata[6];
      if (wr_at(12'h163)) code_q <= reg_wdata;
      if (wr_at(12'h0A6)) msk_q[3:1] <= reg_wdata[2:0];
      if (wr_at(12'h1A1)) msk_q[0] <= reg_wdata[4];
      if (hold_q) ab_q <= 4'h7;
      else if (tx_link_slot && ab_q != 4'h0) ab_q <= ab_q - 4'h1;
    end
  end
  rd_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 8'h00)
    else $error("read data not idle");
  far_addr_a: assert property (reg_rd && reg_addr < BASE |=> reg_rdata_q == 8'h00)
    else $error("foreign framer address answered");
  code_back_a: assert property (reg_rd && reg_addr == BASE + 12'h163 |=> reg_rdata_q == code_q)
    else $error("code register read back wrong");
  valid_pulse_a: assert property (tx_link_slot |=> tx_link_valid_q ##1 !tx_link_valid_q)
    else $error("transmit valid not a one cycle pulse");
  e1_fbit_a: assert property (tx_link_slot && !line_t1_mode |=> tx_link_bit_q == $past(tx_serial_fbit))
    else $error("link logic active outside T1");
  pass_fbit_a: assert property (tx_link_slot && pt_q |=> tx_link_bit_q == $past(tx_serial_fbit))
    else $error("pass-through bit not sent");
  irq_mask_a: assert property (msk_q == 4'h0 |=> interrupt_out_n_q)
    else $error("interrupt with all masks off");
  abort_ones_a: assert property (tx_link_slot && ab_q != 4'h0 && !pt_q && line_t1_mode && line_esf_mode
    |=> tx_link_bit_q)
    else $error("abort bit not one");
endmodule
bind tdlb_link tdlb_link_monitor #(.FRAMER_NUM(FRAMER_NUM)) u_mon (.*);
`default_nettype wire

// ### testbench/tdlb_link_test.sv
// Self-checking bench for the T1 data link block
`timescale 1ns/10ps
`default_nettype none
module tdlb_link_test;
  localparam logic [11:0] BASE = 12'h200; // Second framer window
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata_q;
  logic line_t1_mode = 1'b1;
  logic line_esf_mode = 1'b1;
  logic tx_serial_fbit = 1'b0;
  logic tx_link_slot, tx_link_bit_q, tx_link_valid_q, rx_link_slot, rx_link_bit, rx_mf_start, interrupt_out_n_q;
  logic [15:0] rx_pattern = 16'h005F; // Streamed received bits
  logic [4:0] rx_len = 5'h08;
  logic [31:0] tx_hist;
  logic [7:0] rd_q; // Last read data
  int n_fail = 0;
  int cmp_count = 0;
  always #12.5 clk_sys = ~clk_sys;
  tdlb_link #(.FRAMER_NUM(4'h2)) dut (.*);
  tdlb_far_end #(.GAP(8)) far (.clk_sys(clk_sys), .rst(rst), .rx_pattern(rx_pattern), .rx_len(rx_len),
    .d4_mode(!line_esf_mode), .tx_link_bit_q(tx_link_bit_q), .tx_link_valid_q(tx_link_valid_q),
    .tx_link_slot(tx_link_slot), .rx_link_slot(rx_link_slot), .rx_link_bit(rx_link_bit),
    .rx_mf_start(rx_mf_start), .tx_hist(tx_hist));
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus cycles; offsets are relative to this framer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= BASE + a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= BASE + a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata_q;
  endtask
  // Bounded wait for a status bit, cleared n-1 times so stale flags drop out
  task automatic drain(input logic [11:0] a, input int b, input int n);
    int i;
    for (int k = 0; k < n; k++) begin
      i = 0;
      if (k > 0) wr(a, 8'h01 << b);
      rd(a);
      while (rd_q[b] !== 1'b1 && i < 400) begin
        rd(a);
        i++;
      end
      chk(rd_q[b], 1'b1);
    end
  endtask
  task automatic wait_slots(input int n);
    repeat (n * 8) @(posedge clk_sys);
  endtask
  // True when h holds a run of the repeating 16-bit pattern p at any phase
  function automatic logic rot_ok(input logic [31:0] h, input logic [15:0] p);
    logic ok;
    rot_ok = 1'b0;
    for (int r = 0; r < 16; r++) begin
      ok = 1'b1;
      for (int k = 0; k < 32; k++) if (h[k] !== p[(k + r) % 16]) ok = 1'b0;
      if (ok) rot_ok = 1'b1;
    end
  endfunction
  task automatic t_regs();
    logic [11:0] rw [8] = '{12'h015, 12'h0A6, 12'h113, 12'h162, 12'h163, 12'h181, 12'h182, 12'h1A1};
    foreach (rw[i]) begin
      rd(rw[i]);
      chk(rd_q, 8'h00);
      wr(rw[i], 8'h5A);
      rd(rw[i]);
      chk(rd_q, 8'h5A);
      wr(rw[i], 8'h00);
    end
    wr(12'h063, 8'h3C);
    rd(12'h063);
    chk(rd_q, 8'h00);
    rd(12'h000);
    chk(rd_q, 8'h00);
    wr(12'h163, 8'h2B);
    rd(12'hF63);
    chk(rd_q, 8'h00);
    rd(12'h163);
    chk(rd_q, 8'h2B);
    wr(12'h163, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_rx_byte();
    wr(12'h0A6, 8'h04);
    drain(12'h096, 2, 2);
    chk(interrupt_out_n_q, 1'b0);
    rd(12'h062);
    chk(rd_q, 8'h5F);
    wr(12'h096, 8'h04);
    rd(12'h096);
    chk(rd_q[2], 1'b0);
    wr(12'h0A6, 8'h00);
    $display("test rx byte done");
  endtask
  task automatic t_rx_code();
    rx_pattern <= 16'hFF2A;
    rx_len <= 5'h10;
    wr(12'h015, 8'h00);
    wr(12'h0A6, 8'h01);
    drain(12'h096, 0, 1);
    chk(interrupt_out_n_q, 1'b0);
    rd(12'h063);
    chk(rd_q, 8'h15);
    wr(12'h096, 8'h01);
    wait_slots(48);
    rd(12'h096);
    chk(rd_q[0], 1'b0);
    rx_pattern <= 16'h00FF;
    rx_len <= 5'h08;
    wr(12'h0A6, 8'h02);
    drain(12'h096, 1, 1);
    chk(interrupt_out_n_q, 1'b0);
    wr(12'h0A6, 8'h00);
    $display("test rx code done");
  endtask
  task automatic t_tx_byte();
    wr(12'h162, 8'hF9);
    wr(12'h191, 8'h10);
    wr(12'h1A1, 8'h10);
    wr(12'h182, 8'h80);
    drain(12'h191, 4, 3);
    chk(rd_q, 8'h10);
    chk(interrupt_out_n_q, 1'b0);
    chk(tx_hist[31:16], 16'hF9F9);
    wr(12'h1A1, 8'h00);
    $display("test tx byte done");
  endtask
  task automatic t_tx_code();
    wr(12'h182, 8'h00);
    wr(12'h163, 8'hD2);
    wr(12'h113, 8'h40);
    wait_slots(40);
    chk(rot_ok(tx_hist, 16'hFF24), 1'b1);
    wr(12'h181, 8'h40);
    wait_slots(6);
    chk(tx_hist[31:28], 4'h0);
    wr(12'h181, 8'h00);
    wr(12'h113, 8'h00);
    wait_slots(20);
    chk(tx_hist[31:24], 8'h00);
    line_t1_mode <= 1'b0;
    tx_serial_fbit <= 1'b1;
    wr(12'h113, 8'h40);
    wait_slots(20);
    chk(tx_hist[31:16], 16'hFFFF);
    wr(12'h113, 8'h00);
    line_t1_mode <= 1'b1;
    tx_serial_fbit <= 1'b0;
    $display("test tx code done");
  endtask
  task automatic t_d4();
    line_esf_mode <= 1'b0;
    rx_pattern <= 16'h002D;
    rx_len <= 5'h06;
    wr(12'h162, 8'hDC);
    wr(12'h191, 8'h10);
    drain(12'h191, 4, 3);
    chk(tx_hist[31:20], 12'h71C);
    drain(12'h096, 2, 3);
    rd(12'h062);
    chk(rd_q, 8'h2D);
    $display("test d4 done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_rx_byte();
    t_rx_code();
    t_tx_byte();
    t_tx_code();
    t_d4();
    end_sim();
  end
  // Hang guard, far beyond the few thousand cycles the tests need
  initial begin
    #1_000_000;
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
